// file: verilog/flash_cfg_defines.vh
// Purpose: shared constants of the flash LED configuration bank
// Assumes: 25 MHz core clock
// Notes: offsets, fields, reset values and timing figures
`ifndef FLASH_CFG_DEFINES_VH
`define FLASH_CFG_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_HZ 25000000
`define CLK_MHZ 25
`define RAMP_BASE_US 8
`define RAMP_BASE_CYCLES (`RAMP_BASE_US * `CLK_MHZ)
`define FLASH_UNIT_MS 50
`define FLASH_UNIT_CYCLES (`FLASH_UNIT_MS * (`CLK_HZ / 1000))
`define IND_PWM_HZ 31500
`define IND_PWM_PERIOD (`CLK_HZ / `IND_PWM_HZ)
`define IND_SLICES 16
`define IND_SLICE_CYCLES (`IND_PWM_PERIOD / `IND_SLICES)
`define IND_DUTY_BASE 10'h002
// sized counts for the counters: 200 clocks, 50 ms, 793 clocks, 49 clocks
`define RAMP_BASE_LAST 8'hc7
`define FLASH_UNIT_DEFAULT 24'h1312d0
`define IND_PWM_LAST 10'h318
`define IND_SLICE_LEN 10'h031

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PEAK 8'h02
`define OFS_TIMER 8'h03
`define OFS_LOWBAT 8'h04
`define OFS_IND 8'h05
`define OFS_FLASH 8'h06
`define OFS_REDUCED 8'h07

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_PEAK 8'h08
`define RST_TIMER 8'h10
`define RST_LOWBAT 8'hf0
`define RST_IND 8'h14
`define RST_CUR 8'h10
`define MASK_PEAK 8'h1c
`define MASK_TIMER 8'hfb
`define MASK_LOWBAT 8'hf0
`define MASK_IND 8'hff
`define MASK_CUR 8'h3f

// ----------------------------------------
// field positions
// ----------------------------------------
`define FLD_IL_LIMIT 4:3
`define FLD_STRETCH_DIS 2
`define FLD_DURATION 7:4
`define FLD_KEEP_MODE 3
`define FLD_SW_FREQ 1:0
`define FLD_LB_THRESH 7:5
`define FLD_LB_RESP 4
`define FLD_DERATE 7
`define FLD_RAMP_STEP 6:4
`define FLD_HEADROOM 3:2
`define FLD_IND_DUTY 1:0
`define FLD_CUR 5:0

// ----------------------------------------
// codes
// ----------------------------------------
`define MODE_INDICATOR 2'b01
`define MODE_FLASH 2'b11
`define LB_DISABLED 3'b111
`define I2C_ADDR_DEFAULT 7'h2a

`endif

// file: verilog/ramp_step_timer.v
// Purpose: one-cycle tick per current ramp step
// Assumes: run_i held high while ramping or in the pulse
// Notes: step length is base period times (code + 1)
`timescale 1ns/1ps
`include "flash_cfg_defines.vh"

module ramp_step_timer
(
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // control
  input wire run_i,
  input wire [2:0] step_code_i,
  // tick
  output reg tick_o
);

  reg [7:0] base_cnt_reg;
  reg [2:0] unit_cnt_reg;
  wire base_done;

  assign base_done = (base_cnt_reg == `RAMP_BASE_LAST);

  // ----------------------------------------
  // base counter and step unit counter
  // ----------------------------------------
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      base_cnt_reg <= 8'h00;
      unit_cnt_reg <= 3'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (!run_i)
      begin
        base_cnt_reg <= 8'h00;
        unit_cnt_reg <= 3'h0;
      end
      else if (base_done)
      begin
        base_cnt_reg <= 8'h00;
        if (unit_cnt_reg >= step_code_i)
        begin
          unit_cnt_reg <= 3'h0;
          tick_o <= 1'b1;
        end
        else
          unit_cnt_reg <= unit_cnt_reg + 3'h1;
      end
      else
        base_cnt_reg <= base_cnt_reg + 8'h01;
    end
  end

endmodule

// file: verilog/flash_led_config_registers.v
// Purpose: configuration bank 0x02..0x07 of a flash LED driver, I2C reached
// Assumes: scl/sda inputs synchronous to core_clk_i; analog compares as inputs
// Notes: drives the flash current code, timeout and indicator PWM
`timescale 1ns/1ps
`include "flash_cfg_defines.vh"

module flash_led_config_registers
#(
  parameter [6:0] DEV_ADDR = `I2C_ADDR_DEFAULT, // arbitrary bus address
  parameter [23:0] FLASH_UNIT_CYCLES = `FLASH_UNIT_DEFAULT
)
(
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // serial register port
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe_o,
  // device state from outside this bank
  input wire [1:0] operating_mode_field_i,
  input wire flash_trigger_i,
  input wire event_end_i,
  input wire tx_i,
  input wire vin_below_thresh_i,
  input wire temp_over_130_i,
  // converter settings
  output wire [1:0] inductor_limit_select_o,
  output wire freq_stretch_disable_o,
  output wire [1:0] switching_freq_select_o,
  output wire [2:0] low_battery_threshold_o,
  output wire [1:0] pass_mode_headroom_o,
  // flash control
  output reg [5:0] flash_current_o,
  output reg flash_timeout_o,
  output reg mode_reset_o,
  output reg device_disable_o,
  output reg indicator_pwm_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_ADDR_ACK = 4'h2;
  localparam S_PTR = 4'h3;
  localparam S_PTR_ACK = 4'h4;
  localparam S_WR = 4'h5;
  localparam S_WR_ACK = 4'h6;
  localparam S_RD = 4'h7;
  localparam S_RD_ACK = 4'h8;

  localparam F_IDLE = 2'h0;
  localparam F_RAMP = 2'h1;
  localparam F_PULSE = 2'h2;
  localparam F_OFF = 2'h3;

  reg [7:0] peak_limit_and_stretch_reg;
  reg [7:0] flash_timer_and_frequency_reg;
  reg [7:0] low_battery_setting_reg;
  reg [7:0] indicator_and_ramp_setting_reg;
  reg [7:0] flash_current_setting_reg;
  reg [7:0] reduced_flash_current_reg;

  reg scl_q_reg;
  reg sda_q_reg;
  reg [3:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg byte_full_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg read_dir_reg;
  reg master_nack_reg;
  reg wr_en_reg;
  reg [7:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg [7:0] rd_mux;

  reg [1:0] fstate_reg;
  reg trig_q_reg;
  reg reduced_start_reg;
  reg [23:0] unit_cnt_reg;
  reg [3:0] units_reg;
  reg [9:0] pwm_cnt_reg;
  reg [5:0] target_code;

  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire step_tick;
  wire flash_mode;
  wire low_batt;
  wire flash_run;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // smaller of two current codes
  function [5:0] min_code;
    input [5:0] a;
    input [5:0] b;
    begin
      min_code = (a < b) ? a : b;
    end
  endfunction

  // masked write value, reserved bits forced low
  function [7:0] masked;
    input [7:0] d;
    input [7:0] m;
    begin
      masked = d & m;
    end
  endfunction

  // ----------------------------------------
  // bus line events
  // ----------------------------------------
  assign scl_rise = scl_i & ~scl_q_reg;
  assign scl_fall = ~scl_i & scl_q_reg;
  assign bus_start = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
  assign bus_stop = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
  assign sda_o = 1'b0; // open drain, only pulls low

  // read data for the current pointer
  always @*
  begin
    case (ptr_reg)
      `OFS_PEAK: rd_mux = peak_limit_and_stretch_reg;
      `OFS_TIMER: rd_mux = flash_timer_and_frequency_reg;
      `OFS_LOWBAT: rd_mux = low_battery_setting_reg;
      `OFS_IND: rd_mux = indicator_and_ramp_setting_reg;
      `OFS_FLASH: rd_mux = flash_current_setting_reg;
      `OFS_REDUCED: rd_mux = reduced_flash_current_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // serial slave: address, pointer, data
  // ----------------------------------------
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      state_reg <= S_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_full_reg <= 1'b0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      read_dir_reg <= 1'b0;
      master_nack_reg <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
      wr_en_reg <= 1'b0;
      if (bus_start)
      begin
        state_reg <= S_ADDR;
        bit_cnt_reg <= 3'h0;
        byte_full_reg <= 1'b0;
        sda_oe_o <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= S_IDLE;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_ADDR, S_PTR, S_WR:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_i};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              byte_full_reg <= (bit_cnt_reg == 3'h7);
            end
            else if (scl_fall && byte_full_reg)
            begin
              byte_full_reg <= 1'b0;
              if (state_reg == S_ADDR)
              begin
                if (shift_reg[7:1] == DEV_ADDR)
                begin
                  read_dir_reg <= shift_reg[0];
                  sda_oe_o <= 1'b1;
                  state_reg <= S_ADDR_ACK;
                end
                else
                  state_reg <= S_IDLE;
              end
              else if (state_reg == S_PTR)
              begin
                ptr_reg <= shift_reg;
                sda_oe_o <= 1'b1;
                state_reg <= S_PTR_ACK;
              end
              else
              begin
                wr_en_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
                sda_oe_o <= 1'b1;
                state_reg <= S_WR_ACK;
              end
            end
          end
          S_ADDR_ACK, S_PTR_ACK, S_WR_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt_reg <= 3'h0;
              if (state_reg == S_ADDR_ACK && read_dir_reg)
              begin
                shift_reg <= rd_mux;
                sda_oe_o <= ~rd_mux[7];
                state_reg <= S_RD;
              end
              else
              begin
                sda_oe_o <= 1'b0;
                state_reg <= (state_reg == S_ADDR_ACK) ? S_PTR : S_WR;
              end
            end
          end
          S_RD:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_reg == 3'h7)
              begin
                sda_oe_o <= 1'b0;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= S_RD_ACK;
              end
              else
              begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_o <= ~shift_reg[6];
              end
            end
          end
          S_RD_ACK:
          begin
            if (scl_rise)
              master_nack_reg <= sda_i;
            else if (scl_fall)
            begin
              if (master_nack_reg)
                state_reg <= S_IDLE;
              else
              begin
                bit_cnt_reg <= 3'h0;
                shift_reg <= rd_mux;
                sda_oe_o <= ~rd_mux[7];
                state_reg <= S_RD;
              end
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peak_limit_and_stretch_reg <= `RST_PEAK;
      flash_timer_and_frequency_reg <= `RST_TIMER;
      low_battery_setting_reg <= `RST_LOWBAT;
      indicator_and_ramp_setting_reg <= `RST_IND;
      flash_current_setting_reg <= `RST_CUR;
      reduced_flash_current_reg <= `RST_CUR;
    end
    else if (wr_en_reg)
    begin
      case (wr_addr_reg)
        `OFS_PEAK: peak_limit_and_stretch_reg <= masked(wr_data_reg, `MASK_PEAK);
        `OFS_TIMER: flash_timer_and_frequency_reg <= masked(wr_data_reg, `MASK_TIMER);
        `OFS_LOWBAT: low_battery_setting_reg <= masked(wr_data_reg, `MASK_LOWBAT);
        `OFS_IND: indicator_and_ramp_setting_reg <= masked(wr_data_reg, `MASK_IND);
        `OFS_FLASH: flash_current_setting_reg <= masked(wr_data_reg, `MASK_CUR);
        `OFS_REDUCED: reduced_flash_current_reg <= masked(wr_data_reg, `MASK_CUR);
        default: ;
      endcase
    end
  end

  // converter settings straight from the fields
  assign inductor_limit_select_o = peak_limit_and_stretch_reg[`FLD_IL_LIMIT];
  assign freq_stretch_disable_o = peak_limit_and_stretch_reg[`FLD_STRETCH_DIS];
  assign switching_freq_select_o = flash_timer_and_frequency_reg[`FLD_SW_FREQ];
  assign low_battery_threshold_o = low_battery_setting_reg[`FLD_LB_THRESH];
  assign pass_mode_headroom_o = indicator_and_ramp_setting_reg[`FLD_HEADROOM];

  // ----------------------------------------
  // flash current sequencing
  // ----------------------------------------
  assign flash_mode = (operating_mode_field_i == `MODE_FLASH);
  assign low_batt = vin_below_thresh_i & flash_mode &
    (low_battery_setting_reg[`FLD_LB_THRESH] != `LB_DISABLED);
  assign flash_run = (fstate_reg == F_RAMP) || (fstate_reg == F_PULSE);

  // ceiling on the flash current
  always @*
  begin
    target_code = flash_current_setting_reg[`FLD_CUR];
    if (tx_i || reduced_start_reg ||
        (indicator_and_ramp_setting_reg[`FLD_DERATE] && temp_over_130_i))
      target_code = min_code(target_code, reduced_flash_current_reg[`FLD_CUR]);
  end

  ramp_step_timer u_step
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(flash_run),
    .step_code_i(indicator_and_ramp_setting_reg[`FLD_RAMP_STEP]),
    .tick_o(step_tick)
  );

  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fstate_reg <= F_IDLE;
      trig_q_reg <= 1'b0;
      reduced_start_reg <= 1'b0;
      flash_current_o <= 6'h00;
      device_disable_o <= 1'b0;
      flash_timeout_o <= 1'b0;
      mode_reset_o <= 1'b0;
      unit_cnt_reg <= 24'h000000;
      units_reg <= 4'h0;
    end
    else
    begin
      trig_q_reg <= flash_trigger_i;
      flash_timeout_o <= 1'b0;
      mode_reset_o <= event_end_i & ~flash_timer_and_frequency_reg[`FLD_KEEP_MODE];
      if (flash_run)
      begin
        if (unit_cnt_reg == FLASH_UNIT_CYCLES - 24'h000001)
        begin
          unit_cnt_reg <= 24'h000000;
          units_reg <= units_reg + 4'h1;
        end
        else
          unit_cnt_reg <= unit_cnt_reg + 24'h000001;
      end
      else
      begin
        unit_cnt_reg <= 24'h000000;
        units_reg <= 4'h0;
      end
      case (fstate_reg)
        F_IDLE:
        begin
          flash_current_o <= 6'h00;
          device_disable_o <= 1'b0;
          if (flash_trigger_i && !trig_q_reg && flash_mode)
          begin
            if (low_batt && low_battery_setting_reg[`FLD_LB_RESP])
              fstate_reg <= F_OFF;
            else
            begin
              reduced_start_reg <= low_batt;
              fstate_reg <= F_RAMP;
            end
          end
        end
        F_RAMP, F_PULSE:
        begin
          if (!flash_trigger_i || !flash_mode)
          begin
            fstate_reg <= F_IDLE;
            reduced_start_reg <= 1'b0;
          end
          else if (units_reg == flash_timer_and_frequency_reg[`FLD_DURATION] &&
                   unit_cnt_reg == FLASH_UNIT_CYCLES - 24'h000001)
          begin
            flash_timeout_o <= 1'b1;
            fstate_reg <= F_IDLE;
            reduced_start_reg <= 1'b0;
          end
          else if (flash_current_o > target_code)
            flash_current_o <= target_code;
          else if (step_tick)
          begin
            if (fstate_reg == F_RAMP)
            begin
              if (low_batt)
                fstate_reg <= F_PULSE;
              else if (flash_current_o < target_code)
                flash_current_o <= flash_current_o + 6'h01;
              else
                fstate_reg <= F_PULSE;
            end
            else if (low_batt && flash_current_o != 6'h00)
              flash_current_o <= flash_current_o - 6'h01;
          end
        end
        F_OFF:
        begin
          device_disable_o <= 1'b1;
          flash_current_o <= 6'h00;
          if (!flash_trigger_i)
            fstate_reg <= F_IDLE;
        end
        default: fstate_reg <= F_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // indicator PWM
  // ----------------------------------------
  always @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwm_cnt_reg <= 10'h000;
      indicator_pwm_o <= 1'b0;
    end
    else
    begin
      if (pwm_cnt_reg == `IND_PWM_LAST)
        pwm_cnt_reg <= 10'h000;
      else
        pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
      indicator_pwm_o <= (operating_mode_field_i == `MODE_INDICATOR) &&
        (pwm_cnt_reg < `IND_SLICE_LEN *
          ({8'h00, indicator_and_ramp_setting_reg[`FLD_IND_DUTY]} + `IND_DUTY_BASE));
    end
  end

endmodule

// file: sim/flash_cfg_monitor.sv
// Purpose: port checker for the flash configuration bank
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to the design top module
`timescale 1ns/1ps
module flash_cfg_monitor
(
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // serial port
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  // device state
  input wire [1:0] operating_mode_field_i,
  input wire flash_trigger_i,
  input wire event_end_i,
  // observed outputs
  input wire [1:0] inductor_limit_select_o,
  input wire [2:0] low_battery_threshold_o,
  input wire [5:0] flash_current_o,
  input wire flash_timeout_o,
  input wire mode_reset_o,
  input wire device_disable_o,
  input wire indicator_pwm_o
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // serial port and register fields
  // ----------------------------------------
  property p_sda_pull_only;
    sda_o == 1'b0;
  endproperty
  a_sda_pull_only: assert property (p_sda_pull_only) else $error("sda driven high");
  property p_sda_moves_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_sda_moves_scl_low: assert property (p_sda_moves_scl_low) else $error("sda moved, scl high");
  property p_fields_land_scl_low;
    $changed({inductor_limit_select_o, low_battery_threshold_o}) |-> !scl_i;
  endproperty
  a_fields_land_scl_low: assert property (p_fields_land_scl_low) else $error("field moved");

  // ----------------------------------------
  // flash control
  // ----------------------------------------
  property p_mode_reset_cause;
    mode_reset_o |-> $past(event_end_i) && !$past(mode_reset_o);
  endproperty
  a_mode_reset_cause: assert property (p_mode_reset_cause) else $error("stray mode reset");
  property p_timeout_single;
    flash_timeout_o |=> !flash_timeout_o && flash_current_o == 6'h00;
  endproperty
  a_timeout_single: assert property (p_timeout_single) else $error("timeout pulse bad");
  property p_current_steps_one;
    flash_current_o > $past(flash_current_o) |-> flash_current_o == $past(flash_current_o) + 6'h01;
  endproperty
  a_current_steps_one: assert property (p_current_steps_one) else $error("current jumped");
  property p_disable_cause;
    device_disable_o |-> $past(flash_trigger_i) || $past(flash_trigger_i, 2);
  endproperty
  a_disable_cause: assert property (p_disable_cause) else $error("disable w/o trigger");
  property p_idle_zero;
    !flash_trigger_i [*3] |-> flash_current_o == 6'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("current while idle");
  property p_pwm_mode;
    indicator_pwm_o |-> $past(operating_mode_field_i) == 2'b01;
  endproperty
  a_pwm_mode: assert property (p_pwm_mode) else $error("pwm outside indicator");

  // main scenarios reached
  cover property (flash_timeout_o);
  cover property (device_disable_o);
  cover property ($rose(mode_reset_o));
endmodule

bind flash_led_config_registers flash_cfg_monitor mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .flash_trigger_i(flash_trigger_i),
  .operating_mode_field_i(operating_mode_field_i), .event_end_i(event_end_i),
  .inductor_limit_select_o(inductor_limit_select_o), .flash_current_o(flash_current_o),
  .low_battery_threshold_o(low_battery_threshold_o), .flash_timeout_o(flash_timeout_o),
  .mode_reset_o(mode_reset_o), .device_disable_o(device_disable_o),
  .indicator_pwm_o(indicator_pwm_o));

// file: sim/i2c_host_model.sv
// Purpose: serial host that reaches the register bank
// Assumes: scl high for 5 core clocks and low for 6 per bit, pull-up on sda
// Notes: counts every byte the device fails to acknowledge
`timescale 1ns/1ps
module i2c_host_model
#(
  parameter [6:0] ADDR = 7'h2a // arbitrary bus address
)
(
  // clock
  input wire core_clk_i,
  // serial wire
  input wire sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  logic [7:0] bytes [0:5];
  int nacks = 0;

  // idle bus
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // wait clocks, then step off the edge
  task hold(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // one bit: data set while scl low, line sampled late in the high half
  task clk_bit(input logic b, output logic s);
    sda_low_o = !b;
    hold(5);
    scl_o = 1'b1;
    hold(4);
    s = sda_i;
    hold(1);
    scl_o = 1'b0;
    hold(1);
  endtask

  // start or repeated start, and stop
  task start();
    sda_low_o = 1'b0;
    hold(5);
    scl_o = 1'b1;
    hold(5);
    sda_low_o = 1'b1;
    hold(5);
    scl_o = 1'b0;
  endtask
  task stop();
    sda_low_o = 1'b1;
    hold(5);
    scl_o = 1'b1;
    hold(5);
    sda_low_o = 1'b0;
    hold(5);
  endtask

  // byte out msb first, then the device's acknowledge bit
  task byte_out(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    if (s) nacks++;
  endtask
  task byte_in(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
  endtask

  // address, offset, then n data bytes
  task wr(input logic [6:0] a, input logic [7:0] ofs, input int n);
    start();
    byte_out({a, 1'b0});
    byte_out(ofs);
    for (int i = 0; i < n; i++) byte_out(bytes[i]);
    stop();
  endtask
  task rd(input logic [7:0] ofs, input int n);
    start();
    byte_out({ADDR, 1'b0});
    byte_out(ofs);
    start();
    byte_out({ADDR, 1'b1});
    for (int i = 0; i < n; i++) byte_in(i == n - 1, bytes[i]);
    stop();
  endtask
endmodule

// file: sim/flash_led_config_registers_tb.sv
// Purpose: self-checking bench for the flash configuration bank
// Assumes: host model drives the serial port, 25 MHz core clock
// Notes: flash time unit shortened to 2000 clocks
`timescale 1ns/1ps
module flash_led_config_registers_tb;
  logic clk, rst, scl, host_low, sda_o, sda_oe, trig, evt, tx, vin, temp;
  logic stretch, tmo, mrst, dis, pwm;
  logic [1:0] mode, ilim, freq, head;
  logic [2:0] thr;
  logic [5:0] cur;
  logic [7:0] rst_tab [0:5] = '{8'h08, 8'h10, 8'hf0, 8'h14, 8'h10, 8'h10};
  logic [7:0] msk_tab [0:5] = '{8'h1c, 8'hfb, 8'hf0, 8'hff, 8'h3f, 8'h3f};
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  wire sda_w = !host_low && (sda_oe ? sda_o : 1'b1);

  flash_led_config_registers #(.DEV_ADDR(7'h2a), .FLASH_UNIT_CYCLES(24'd2000)) dut (
    .core_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .operating_mode_field_i(mode), .flash_trigger_i(trig), .event_end_i(evt), .tx_i(tx),
    .vin_below_thresh_i(vin), .temp_over_130_i(temp), .inductor_limit_select_o(ilim),
    .freq_stretch_disable_o(stretch), .switching_freq_select_o(freq),
    .low_battery_threshold_o(thr), .pass_mode_headroom_o(head), .flash_current_o(cur),
    .flash_timeout_o(tmo), .mode_reset_o(mrst), .device_disable_o(dis), .indicator_pwm_o(pwm));
  i2c_host_model #(.ADDR(7'h2a)) host (.core_clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task put(input logic [7:0] ofs, input logic [7:0] d);
    host.bytes[0] = d;
    host.wr(7'h2a, ofs, 1);
  endtask
  task fire(input int k, input logic [5:0] exp);
    trig = 1'b1;
    step(k);
    check({2'b00, cur}, {2'b00, exp});
    trig = 1'b0;
    step(8);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    {rst, trig, evt, tx, vin, temp, mode} = 8'h80;
    step(16);
    rst = 1'b0;
    host.rd(8'h02, 6);
    for (int i = 0; i < 6; i++) check(host.bytes[i], rst_tab[i]);
    check({1'b0, stretch, freq, head, ilim}, 8'h05);
    check({5'h00, thr}, 8'h07);
    $display("reset values done");
    for (int i = 0; i < 6; i++) host.bytes[i] = 8'hff;
    host.wr(7'h2a, 8'h02, 6);
    check({1'b0, stretch, freq, head, ilim}, 8'h7f);
    host.rd(8'h02, 6);
    for (int i = 0; i < 6; i++) check(host.bytes[i], msk_tab[i]);
    put(8'h10, 8'h5a);
    host.rd(8'h10, 1);
    check(host.bytes[0], 8'h00);
    n = host.nacks;
    host.wr(7'h2b, 8'h02, 1);
    check(8'(host.nacks - n), 8'h03);
    host.rd(8'h02, 1);
    check(host.bytes[0], 8'h1c);
    $display("register access done");
    host.bytes = '{8'h00, 8'hf0, 8'h00, 8'h03, 8'h3f, 8'h00};
    host.wr(7'h2a, 8'h03, 5);
    mode = 2'b11;
    fire(300, 6'h01);
    fire(1000, 6'h03);
    tx = 1'b1;
    put(8'h07, 8'h01);
    fire(1000, 6'h01);
    tx = 1'b0;
    temp = 1'b1;
    put(8'h05, 8'h80);
    fire(1000, 6'h01);
    put(8'h05, 8'h00);
    fire(1000, 6'h03);
    temp = 1'b0;
    vin = 1'b1;
    fire(1000, 6'h03);
    put(8'h04, 8'h10);
    trig = 1'b1;
    step(20);
    check({7'h00, dis}, 8'h01);
    trig = 1'b0;
    step(8);
    check({7'h00, dis}, 8'h00);
    vin = 1'b0;
    put(8'h04, 8'h00);
    trig = 1'b1;
    step(1100);
    vin = 1'b1;
    step(200);
    check({2'b00, cur}, 8'h02);
    {trig, vin} = 2'b00;
    step(8);
    trig = 1'b1;
    step(300);
    vin = 1'b1;
    step(200);
    check({2'b00, cur}, 8'h01);
    {trig, vin} = 2'b00;
    step(8);
    $display("flash current done");
    trig = 1'b1;
    n = 0;
    while (tmo !== 1'b1 && n < 2100)
    begin
      step(1);
      n++;
    end
    check({7'h00, n >= 1995 && n <= 2005}, 8'h01);
    step(1);
    check({2'b00, cur}, 8'h00);
    trig = 1'b0;
    evt = 1'b1;
    step(1);
    evt = 1'b0;
    check({7'h00, mrst}, 8'h01);
    put(8'h03, 8'h08);
    evt = 1'b1;
    step(1);
    evt = 1'b0;
    check({7'h00, mrst}, 8'h00);
    $display("timeout and mode reset done");
    mode = 2'b01;
    for (int c = 0; c < 4; c++)
    begin
      put(8'h05, 8'(c));
      step(800);
      n = 0;
      repeat (793)
      begin
        step(1);
        n += pwm;
      end
      check(8'(n), 8'(49 * (c + 2)));
    end
    $display("indicator duty done");
    give_verdict;
  end
endmodule
